// ==== verilog/dual_conv_consts.vh ====
`ifndef DUAL_CONV_CONSTS_VH
`define DUAL_CONV_CONSTS_VH

// register byte offsets
`define REG_CTRL_OFS        8'h00
`define REG_STATUS_OFS      8'h04
`define REG_RES_A_OFS       8'h08
`define REG_RES_B_OFS       8'h0c
`define REG_SAMPLE_CNT_OFS  8'h10

// control field positions
`define CTRL_OE_A_N_BIT     0
`define CTRL_OE_B_N_BIT     1
`define CTRL_PD_BIT         2
`define CTRL_FMT_BIT        3
`define CTRL_REF_BIT        4
`define CTRL_RESET_VAL      5'h03

// status field positions
`define STAT_PD_BIT         0
`define STAT_VALID_BIT      1

// pipeline timing and result width
`define LATENCY_CYCLES      6
`define RESULT_WIDTH        12

`endif

// ==== verilog/two_entry_buffer.v ====
`timescale 1ns/1ps
module two_entry_buffer #(
    parameter WIDTH = 24
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] store [0:1];
    reg             rd_idx;
    reg             wr_idx;
    reg [1:0]       count;
    wire            do_push;
    wire            do_pop;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = store[rd_idx];
    assign do_push   = in_valid && in_ready;
    assign do_pop    = out_valid && out_ready;

    always @(posedge clk) begin
        if (!rst_n) begin
            rd_idx <= 1'b0;
            wr_idx <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (do_push) begin
                store[wr_idx] <= in_data;
                wr_idx        <= ~wr_idx;
            end
            if (do_pop) begin
                rd_idx <= ~rd_idx;
            end
            if (do_push && !do_pop) begin
                count <= count + 2'h1;
            end else if (do_pop && !do_push) begin
                count <= count - 2'h1;
            end
        end
    end
endmodule // two_entry_buffer

// ==== verilog/dual_adc_digital_interface.v ====
// Contract
// RULE1: sample both inputs every clock edge
// RULE2: active-low per-channel output enables
// RULE3: power-down high stops conversion
// RULE4: format low offset binary, high twos
// RULE5: reference select low internal, high external
// RULE6: two separate 12-bit result buses
// RULE7: partner clocks within range, 66 MHz
// RULE8: bit zero lsb, bit eleven msb
// RULE9: result six cycles after its sample edge
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "dual_conv_consts.vh"
module dual_adc_digital_interface #(
    parameter WIDTH   = `RESULT_WIDTH,
    parameter LATENCY = `LATENCY_CYCLES
) (
    input  wire             clk,
    input  wire             rst_n,
    // sampled analog values, offset binary
    input  wire [WIDTH-1:0] chan_a_sample,
    input  wire [WIDTH-1:0] chan_b_sample,
    // ahb-lite slave
    input  wire             hsel,
    input  wire [7:0]       haddr,
    input  wire [1:0]       htrans,
    input  wire             hwrite,
    input  wire [2:0]       hsize,
    input  wire [31:0]      hwdata,
    input  wire             hready,
    output reg  [31:0]      hrdata,
    output reg              hreadyout,
    output reg              hresp,
    // result pins
    output reg  [WIDTH-1:0] chan_a_result_bus,
    output reg  [WIDTH-1:0] chan_a_result_oe,
    output reg  [WIDTH-1:0] chan_b_result_bus,
    output reg  [WIDTH-1:0] chan_b_result_oe,
    output reg              result_valid,
    input  wire             result_ready,
    output reg              reference_source_select
);
    ////////////////////////////////////////////////////////////////////////
    // control register
    reg  [4:0]          ctrl;
    reg  [4:0]          next_ctrl;
    reg                 wr_pend;
    reg                 next_wr_pend;
    reg  [7:0]          wr_addr;
    wire                chan_a_output_enable_n = ctrl[`CTRL_OE_A_N_BIT];
    wire                chan_b_output_enable_n = ctrl[`CTRL_OE_B_N_BIT];
    wire                power_down_in          = ctrl[`CTRL_PD_BIT];
    wire                number_format_select   = ctrl[`CTRL_FMT_BIT];
    wire                ref_bit                = ctrl[`CTRL_REF_BIT];
    // nonseq and seq both open an access; busy and idle are ignored
    wire                addr_phase = hsel && hready && htrans[1];

    ////////////////////////////////////////////////////////////////////////
    // conversion pipeline
    // sampling register plus shift stages; the buffer write and the output
    // register supply the last two edges of the latency
    localparam STAGES = LATENCY - 1;

    reg  [WIDTH-1:0]    pipe_a [0:STAGES-1];
    reg  [WIDTH-1:0]    pipe_b [0:STAGES-1];
    reg  [STAGES-1:0]   pipe_v;
    reg  [STAGES-1:0]   next_pipe_v;
    // twos complement is offset binary with the msb inverted
    wire [WIDTH-1:0]    msb_flip = {1'b1, {(WIDTH-1){1'b0}}};
    wire [WIDTH-1:0]    fmt_mask = number_format_select ? msb_flip : {WIDTH{1'b0}}; // RULE4

    // powered down, empty slots enter the pipe and no new result appears
    always @* begin
        next_pipe_v = {pipe_v[STAGES-2:0], ~power_down_in}; // RULE3
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            pipe_v <= {STAGES{1'b0}};
        end else begin
            pipe_v <= next_pipe_v;
        end
    end

    // data stages carry no reset; pipe_v alone says which slots are real
    genvar s;
    generate
        for (s = 0; s < STAGES; s = s + 1) begin : g_stage
            if (s == 0) begin : g_sample
                always @(posedge clk) begin
                    pipe_a[s] <= chan_a_sample ^ fmt_mask; // RULE1 RULE4
                    pipe_b[s] <= chan_b_sample ^ fmt_mask; // RULE1 RULE4
                end
            end else begin : g_shift
                always @(posedge clk) begin
                    pipe_a[s] <= pipe_a[s-1]; // RULE9
                    pipe_b[s] <= pipe_b[s-1]; // RULE9
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // output buffer: holds up to two words while the receiver stalls
    // a word that arrives while both entries are full is dropped, since the
    // converter cannot be held off
    wire                buf_out_valid;
    wire [2*WIDTH-1:0]  buf_out_data;
    wire                out_take = !result_valid || result_ready;
    wire                pop      = buf_out_valid && out_take;

    two_entry_buffer #(
        .WIDTH      (2*WIDTH)
    ) u_buf (
        .clk        (clk),
        .rst_n      (rst_n),
        .in_valid   (pipe_v[STAGES-1]),
        .in_ready   (),
        .in_data    ({pipe_b[STAGES-1], pipe_a[STAGES-1]}),
        .out_valid  (buf_out_valid),
        .out_ready  (out_take),
        .out_data   (buf_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // result pins
    reg  [WIDTH-1:0]    next_chan_a_result_bus;
    reg  [WIDTH-1:0]    next_chan_b_result_bus;
    reg                 next_result_valid;
    reg  [31:0]         sample_cnt;
    reg  [31:0]         next_sample_cnt;

    // the word count wraps silently; software works with differences
    always @* begin
        next_chan_a_result_bus = chan_a_result_bus;
        next_chan_b_result_bus = chan_b_result_bus;
        next_result_valid      = result_valid;
        next_sample_cnt        = sample_cnt;
        if (pop) begin
            next_chan_a_result_bus = buf_out_data[WIDTH-1:0]; // RULE6 RULE8
            next_chan_b_result_bus = buf_out_data[2*WIDTH-1:WIDTH]; // RULE6 RULE8
            next_result_valid      = 1'b1;
            next_sample_cnt        = sample_cnt + 32'h00000001;
        end else if (result_ready) begin
            next_result_valid      = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            chan_a_result_bus       <= {WIDTH{1'b0}};
            chan_b_result_bus       <= {WIDTH{1'b0}};
            chan_a_result_oe        <= {WIDTH{1'b0}};
            chan_b_result_oe        <= {WIDTH{1'b0}};
            result_valid            <= 1'b0;
            reference_source_select <= 1'b0;
            sample_cnt              <= 32'h00000000;
        end else begin
            chan_a_result_bus       <= next_chan_a_result_bus;
            chan_b_result_bus       <= next_chan_b_result_bus;
            result_valid            <= next_result_valid;
            sample_cnt              <= next_sample_cnt;
            chan_a_result_oe        <= {WIDTH{~chan_a_output_enable_n}}; // RULE2
            chan_b_result_oe        <= {WIDTH{~chan_b_output_enable_n}}; // RULE2
            reference_source_select <= ref_bit; // RULE5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait states, always okay
    reg  [31:0]         status_word;
    reg  [31:0]         next_hrdata;

    // status shows the buffer, not the pins: a stalled receiver leaves it set
    always @* begin
        status_word                  = 32'h00000000;
        status_word[`STAT_PD_BIT]    = power_down_in; // RULE3
        status_word[`STAT_VALID_BIT] = buf_out_valid;
    end

    // write data follows its address phase by one cycle; other offsets drop it
    always @* begin
        next_wr_pend = addr_phase && hwrite;
        next_ctrl    = ctrl;
        if (wr_pend && wr_addr == `REG_CTRL_OFS) begin
            next_ctrl = hwdata[4:0];
        end
    end

    // read data is registered, so it stands in the data phase that follows
    always @* begin
        next_hrdata = hrdata;
        if (addr_phase && !hwrite) begin
            case (haddr)
                `REG_CTRL_OFS:       next_hrdata = {27'h0000000, ctrl};
                `REG_STATUS_OFS:     next_hrdata = status_word;
                `REG_RES_A_OFS:      next_hrdata = {{(32-WIDTH){1'b0}}, chan_a_result_bus};
                `REG_RES_B_OFS:      next_hrdata = {{(32-WIDTH){1'b0}}, chan_b_result_bus};
                `REG_SAMPLE_CNT_OFS: next_hrdata = sample_cnt;
                default:             next_hrdata = 32'h00000000;
            endcase
        end
    end

    // no wait state is ever needed, so hreadyout and hresp never move
    always @(posedge clk) begin
        if (!rst_n) begin
            ctrl      <= `CTRL_RESET_VAL;
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            ctrl      <= next_ctrl;
            wr_pend   <= next_wr_pend;
            wr_addr   <= haddr;
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
endmodule // dual_adc_digital_interface

// ==== verif/dual_adc_assertions.sv ====
`timescale 1ns/1ps
module dual_adc_assertions #(
    parameter WIDTH = 12
) (
    input wire             clk,
    input wire             rst_n,
    input wire             hsel,
    input wire [7:0]       haddr,
    input wire [1:0]       htrans,
    input wire             hwrite,
    input wire [WIDTH-1:0] chan_a_result_bus,
    input wire [WIDTH-1:0] chan_a_result_oe,
    input wire [WIDTH-1:0] chan_b_result_bus,
    input wire [WIDTH-1:0] chan_b_result_oe,
    input wire             result_valid,
    input wire             result_ready,
    input wire             reference_source_select
);
    // control write address phase; pins may only move two or three edges later
    wire cw = hsel && htrans[1] && hwrite && haddr == 8'h00;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_oe_a; chan_a_result_oe == '0 || chan_a_result_oe == '1; endproperty
    a_oe_a: assert property (p_oe_a) else $error("oe a split");
    property p_oe_b; chan_b_result_oe == '0 || chan_b_result_oe == '1; endproperty
    a_oe_b: assert property (p_oe_b) else $error("oe b split");
    property p_oe_cause;
        $changed(chan_a_result_oe) || $changed(chan_b_result_oe) |-> $past(cw, 2) || $past(cw, 3);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("oe moved alone");
    property p_ref; $changed(reference_source_select) |-> $past(cw, 2) || $past(cw, 3); endproperty
    a_ref: assert property (p_ref) else $error("ref moved alone");
    property p_hold_v; result_valid && !result_ready |=> result_valid; endproperty
    a_hold_v: assert property (p_hold_v) else $error("valid lost");
    property p_hold_a; result_valid && !result_ready |=> $stable(chan_a_result_bus); endproperty
    a_hold_a: assert property (p_hold_a) else $error("bus a moved");
    property p_hold_b; result_valid && !result_ready |=> $stable(chan_b_result_bus); endproperty
    a_hold_b: assert property (p_hold_b) else $error("bus b moved");
    property p_drop; $fell(result_valid) |-> $past(result_ready); endproperty
    a_drop: assert property (p_drop) else $error("word vanished");
endmodule // dual_adc_assertions
bind dual_adc_digital_interface dual_adc_assertions #(.WIDTH(WIDTH)) chk (.*);

// ==== verif/result_sink.sv ====
`timescale 1ns/1ps
// downstream capture logic; stalls when told to
module result_sink (
    input wire clk,
    input wire stall,
    output reg ready
);
    initial ready = 1'b0;
    always @(posedge clk) ready <= !stall;
endmodule // result_sink

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    reg         clk = 0, rst_n = 0, hsel = 0, hwrite = 0, stall = 0;
    reg  [7:0]  haddr = 0;
    reg  [1:0]  htrans = 0;
    reg  [31:0] hwdata = 0, r;
    reg  [11:0] sa = 12'h123, sb = 12'hf0a;
    wire [31:0] hrdata;
    wire [11:0] ba, oa, bb, ob;
    wire        hreadyout, hresp, valid, ready, ref_sel;
    integer     n_fail = 0, total_checks = 0;
    always #2 clk = ~clk;
    dual_adc_digital_interface uut (.clk(clk), .rst_n(rst_n), .chan_a_sample(sa),
        .chan_b_sample(sb), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .chan_a_result_bus(ba), .chan_a_result_oe(oa),
        .chan_b_result_bus(bb), .chan_b_result_oe(ob), .result_valid(valid),
        .result_ready(ready), .reference_source_select(ref_sel));
    result_sink sink (.clk(clk), .stall(stall), .ready(ready));
    task chk(input [31:0] exp, input [31:0] got, input [127:0] what);
        total_checks = total_checks + 1;
        if (exp !== got) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %0s exp %h got %h", what, exp, got);
        end
    endtask
    task ahb(input [7:0] a, input w, input [31:0] d);
        hsel <= 1; haddr <= a; hwrite <= w; htrans <= 2'b10;
        do @(posedge clk); while (!hreadyout);
        htrans <= 2'b00; hwdata <= d;
        do @(posedge clk); while (!hreadyout);
        r = hrdata;
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #20000 n_fail = n_fail + 1;
        report_and_stop;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        ahb(8'h00, 0, 0); chk(32'h3, r, "ctrl");
        chk(0, {oa, ob}, "oe off");
        ahb(8'h14, 0, 0); chk(0, r, "unmapped");
        ahb(8'h00, 1, 32'h0);
        repeat (12) @(posedge clk);
        chk({12'h123, 12'hf0a}, {ba, bb}, "offset");
        chk({24'hffffff, 1'b0}, {oa, ob, ref_sel}, "oe ref");
        ahb(8'h00, 1, 32'h18);
        repeat (12) @(posedge clk);
        chk({12'h923, 12'h70a, 1'b1}, {ba, bb, ref_sel}, "twos ext");
        // channel a off, twos complement and external reference kept
        ahb(8'h00, 1, 32'h19);
        repeat (4) @(posedge clk);
        chk({12'h0, 12'hfff}, {oa, ob}, "oe a only");
        sa <= 12'h5a5;
        // sample taken at the next edge, on the pins six edges after that one
        repeat (6) @(posedge clk);
        #1 chk(12'h923, ba, "early");
        @(posedge clk);
        #1 chk(12'hda5, ba, "latency");
        @(posedge clk);
        stall <= 1;
        repeat (20) @(posedge clk);
        ahb(8'h04, 0, 0); chk(32'h2, r & 32'h3, "stall stat");
        stall <= 0;
        ahb(8'h00, 1, 32'h4);
        repeat (12) @(posedge clk);
        ahb(8'h04, 0, 0); chk(32'h1, r & 32'h3, "pd stat");
        chk(0, valid, "drained");
        report_and_stop;
    end
endmodule // tb_top
